//--- hw/cda_regs.svh
// Constants for the complement and decimal-adjust datapath slice.
`ifndef CDA_REGS_SVH
`define CDA_REGS_SVH
`define CDA_NIBBLE_MAX 4'h9
`define CDA_NIBBLE_FIX 4'h6
`define CDA_DATA_W 8
`endif

//--- hw/cda_pkg.sv
// Types for the complement and decimal-adjust datapath slice.
package cda_pkg;
  typedef enum logic [1:0] {
    OP_IDLE = 2'b00,
    OP_COMPLEMENT = 2'b01,
    OP_ADJUST = 2'b10
  } op_sel_t;
endpackage

//--- hw/decimal_adjuster.sv
// Combinational decimal correction of an accumulator value.
`timescale 1ns/100ps
`include "cda_regs.svh"
module decimal_adjuster (
  // Operand and flags.
  input wire logic [7:0] accum_i,
  input wire logic half_carry_i,
  input wire logic carry_i,
  // Result.
  output logic [7:0] result_o,
  output logic carry_o
);
  logic lo_fix;
  logic hi_fix;
  logic [4:0] lo_sum;
  logic [4:0] hi_mid;
  logic [8:0] sum;
  always_comb begin
    lo_fix = (accum_i[3:0] > `CDA_NIBBLE_MAX) || half_carry_i;
    lo_sum = {1'b0, accum_i[3:0]}
           + {1'b0, (lo_fix ? `CDA_NIBBLE_FIX : 4'h0)};
    // The high nibble is judged after the low correction, so a carry
    // out of the low nibble can push it past nine.
    hi_mid = {1'b0, accum_i[7:4]} + {4'h0, lo_sum[4]};
    hi_fix = (hi_mid > {1'b0, `CDA_NIBBLE_MAX}) || carry_i;
    sum = {1'b0, accum_i}
        + {1'b0, (hi_fix ? `CDA_NIBBLE_FIX : 4'h0),
           (lo_fix ? `CDA_NIBBLE_FIX : 4'h0)};
    result_o = sum[7:0];
    // Carry marks a decimal sum of 100 or more.
    carry_o = sum[8] || carry_i || hi_fix;
  end
endmodule

//--- hw/complement_and_decimal_adjust.sv
// Complement-to-accumulator and decimal-adjust-to-memory datapath.
`timescale 1ns/100ps
`include "cda_regs.svh"
//------------------------------------------------------------------------
//------------------------------------------------------------------------
module complement_and_decimal_adjust
  import cda_pkg::*;
(
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Instruction strobes, one-cycle pulses.
  input wire logic complement_to_accumulator_i,
  input wire logic decimal_adjust_to_memory_i,
  // Operands and flags from the core.
  input wire logic [7:0] mem_rdata_i,
  input wire logic [7:0] working_accumulator_i,
  input wire logic half_carry_flag_i,
  input wire logic carry_flag_i,
  input wire logic zero_flag_i,
  // Results back to the core.
  output logic [7:0] accum_wdata_o,
  output logic accum_we_o,
  output logic [7:0] mem_wdata_o,
  output logic mem_we_o,
  output logic zero_flag_o,
  output logic zero_we_o,
  output logic carry_flag_o,
  output logic carry_we_o,
  output logic done_o
);
  //----------------------------------------------------------------------
  // State
  //----------------------------------------------------------------------
  // Data and flag values hold until the next instruction; the write
  // enables and the done pulse last a single cycle.
  typedef struct packed {
    logic [7:0] accum;
    logic accum_we;
    logic [7:0] mem;
    logic mem_we;
    logic zero;
    logic zero_we;
    logic carry;
    logic carry_we;
    logic done;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic [7:0] adj_val;
  logic adj_carry;
  op_sel_t op;

  //----------------------------------------------------------------------
  // Decimal correction
  //----------------------------------------------------------------------
  // The adjuster is purely combinational; its result only counts when
  // the adjust strobe is taken.
  decimal_adjuster u_adj (
    .accum_i(working_accumulator_i),
    .half_carry_i(half_carry_flag_i),
    .carry_i(carry_flag_i),
    .result_o(adj_val),
    .carry_o(adj_carry)
  );

  //----------------------------------------------------------------------
  // Next state
  //----------------------------------------------------------------------
  // A request dropped on a collision is not reported back; the core is
  // expected to issue one instruction at a time.
  always_comb begin
    // Complement wins if both strobes arrive together.
    if (complement_to_accumulator_i) begin
      op = OP_COMPLEMENT;
    end else if (decimal_adjust_to_memory_i) begin
      op = OP_ADJUST;
    end else begin
      op = OP_IDLE;
    end
    s_d = s_q;
    s_d.accum_we = 1'b0;
    s_d.mem_we = 1'b0;
    s_d.zero_we = 1'b0;
    s_d.carry_we = 1'b0;
    s_d.done = 1'b0;
    case (op)
      OP_COMPLEMENT: begin
        s_d.accum = ~mem_rdata_i;
        s_d.accum_we = 1'b1;
        s_d.mem_we = 1'b0;
        s_d.zero = (~mem_rdata_i == 8'h00);
        s_d.zero_we = 1'b1;
        s_d.carry = carry_flag_i;
        s_d.done = 1'b1;
      end
      OP_ADJUST: begin
        s_d.mem = adj_val;
        s_d.mem_we = 1'b1;
        s_d.carry = adj_carry;
        s_d.carry_we = 1'b1;
        s_d.zero = zero_flag_i;
        s_d.done = 1'b1;
      end
      default: begin
      end
    endcase
  end

  // Synchronous reset clears every result and every pulse.
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  //----------------------------------------------------------------------
  // Outputs
  //----------------------------------------------------------------------
  // Every output is taken straight from the state register.
  assign accum_wdata_o = s_q.accum;
  assign accum_we_o = s_q.accum_we;
  assign mem_wdata_o = s_q.mem;
  assign mem_we_o = s_q.mem_we;
  assign zero_flag_o = s_q.zero;
  assign zero_we_o = s_q.zero_we;
  assign carry_flag_o = s_q.carry;
  assign carry_we_o = s_q.carry_we;
  assign done_o = s_q.done;

  //----------------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------------
  // Each check but chk_one_target looks one cycle after the strobes are sampled, while the
  // registered pulses stand; chk_one_target holds in every cycle.
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  chk_cpl_value: assert property (
    complement_to_accumulator_i |=> accum_we_o
      && accum_wdata_o == ~$past(mem_rdata_i))
    else $error("Complement result wrong.");
  chk_cpl_no_mem: assert property (
    complement_to_accumulator_i |=> !mem_we_o)
    else $error("Complement wrote memory.");
  chk_cpl_mem_held: assert property (
    complement_to_accumulator_i |=> $stable(mem_wdata_o))
    else $error("Complement changed the memory write data.");
  chk_cpl_zero: assert property (
    complement_to_accumulator_i |=> zero_we_o && !carry_we_o
      && zero_flag_o == ($past(mem_rdata_i) == 8'hff))
    else $error("Zero flag wrong after complement.");
  chk_adj_target: assert property (
    (decimal_adjust_to_memory_i && !complement_to_accumulator_i)
      |=> mem_we_o && !accum_we_o)
    else $error("Adjust target wrong.");
  chk_adj_accum_held: assert property (
    (decimal_adjust_to_memory_i && !complement_to_accumulator_i)
      |=> $stable(accum_wdata_o))
    else $error("Adjust changed the accumulator value.");
  chk_one_target: assert property (
    !(accum_we_o && mem_we_o))
    else $error("Both result writes raised together.");
  chk_adj_low: assert property (
    (decimal_adjust_to_memory_i && !complement_to_accumulator_i
      && !half_carry_flag_i && working_accumulator_i[3:0] <= 4'h9)
      |=> mem_wdata_o[3:0] == $past(working_accumulator_i[3:0]))
    else $error("Low nibble altered.");
  chk_adj_high: assert property (
    (decimal_adjust_to_memory_i && !complement_to_accumulator_i
      && carry_flag_i && working_accumulator_i == 8'h00
      && !half_carry_flag_i)
      |=> mem_wdata_o == 8'h60)
    else $error("High correction missing.");
  chk_adj_step: assert property (
    (decimal_adjust_to_memory_i && !complement_to_accumulator_i)
      |=> 8'(mem_wdata_o - $past(working_accumulator_i))
        inside {8'h00, 8'h06, 8'h60, 8'h66})
    else $error("Adjust correction outside the four steps.");
  chk_adj_flags: assert property (
    (decimal_adjust_to_memory_i && !complement_to_accumulator_i)
      |=> carry_we_o && !zero_we_o
      && (carry_flag_o || $past(working_accumulator_i) <= 8'h99))
    else $error("Adjust flag update wrong.");
  chk_adj_carry_kept: assert property (
    (decimal_adjust_to_memory_i && !complement_to_accumulator_i
      && carry_flag_i) |=> carry_flag_o)
    else $error("Adjust dropped an incoming carry.");
  chk_adj_zero_kept: assert property (
    (decimal_adjust_to_memory_i && !complement_to_accumulator_i)
      |=> zero_flag_o == $past(zero_flag_i))
    else $error("Adjust changed the zero flag.");
  chk_done_pulse: assert property (
    (complement_to_accumulator_i || decimal_adjust_to_memory_i)
      |=> done_o && (accum_we_o != mem_we_o))
    else $error("Instruction ended without one result write.");
  chk_idle_quiet: assert property (
    !complement_to_accumulator_i && !decimal_adjust_to_memory_i
      |=> !done_o && !accum_we_o && !mem_we_o)
    else $error("Spurious done or write.");

  //----------------------------------------------------------------------
  // Cover points
  //----------------------------------------------------------------------
  // Main scenarios: a zero result, both corrections, a carry out of an
  // adjust and two instructions on consecutive edges.
  cov_cpl_zero: cover property (
    complement_to_accumulator_i && mem_rdata_i == 8'hff);
  cov_adj_66: cover property (
    decimal_adjust_to_memory_i && working_accumulator_i == 8'hcd);
  cov_adj_carry_out: cover property (
    decimal_adjust_to_memory_i && !complement_to_accumulator_i
      && working_accumulator_i == 8'h9a);
  cov_back_to_back: cover property (
    complement_to_accumulator_i ##1 decimal_adjust_to_memory_i);
endmodule

//--- bench/tb.sv
// Self-checking bench for the complement and decimal-adjust datapath.
`timescale 1ns/100ps
module tb;
  import cda_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic cpl = 1'b0, adj = 1'b0, hc = 1'b0, cy = 1'b0, zf = 1'b0;
  logic [7:0] mem = 8'h00, accum = 8'h00;
  wire [7:0] accum_w, mem_w;
  wire accum_we, mem_we, z_o, z_we, c_o, c_we, done;
  int num_errors = 0;
  int compares = 0;

  complement_and_decimal_adjust uut (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .complement_to_accumulator_i(cpl), .decimal_adjust_to_memory_i(adj),
    .mem_rdata_i(mem), .working_accumulator_i(accum),
    .half_carry_flag_i(hc), .carry_flag_i(cy), .zero_flag_i(zf),
    .accum_wdata_o(accum_w), .accum_we_o(accum_we), .mem_wdata_o(mem_w),
    .mem_we_o(mem_we), .zero_flag_o(z_o), .zero_we_o(z_we),
    .carry_flag_o(c_o), .carry_we_o(c_we), .done_o(done));

  initial begin
    forever #2.5 mclk_i = ~mclk_i;
  end

  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Presents one request, then looks at the answer one cycle later.
  task issue(input logic cs, ds, input logic [7:0] m, a,
             input logic h, c, z);
    @(posedge mclk_i);
    cpl <= cs;
    adj <= ds;
    mem <= m;
    accum <= a;
    hc <= h;
    cy <= c;
    zf <= z;
    @(posedge mclk_i);
    cpl <= 1'b0;
    adj <= 1'b0;
    #1;
  endtask

  task run_complement(input logic [7:0] m);
    issue(1'b1, 1'b0, m, 8'h5a, 1'b1, 1'b1, m != 8'hff);
    chk(accum_w, ~m);
    chk({5'h0, accum_we, mem_we, done}, 8'h05);
    chk({6'h0, z_o, z_we}, {6'h0, m == 8'hff, 1'b1});
    chk({7'h0, c_we}, 8'h00);
  endtask

  task run_adjust(input logic [7:0] a, input logic h, c,
                  input logic [7:0] res, input logic co);
    issue(1'b0, 1'b1, 8'h3c, a, h, c, 1'b1);
    chk(mem_w, res);
    chk({5'h0, accum_we, mem_we, done}, 8'h03);
    chk({6'h0, c_o, c_we}, {6'h0, co, 1'b1});
    chk({7'h0, z_we}, 8'h00);
  endtask

  task run_collision();
    issue(1'b1, 1'b1, 8'h0f, 8'h99, 1'b0, 1'b0, 1'b1);
    chk(accum_w, 8'hf0);
    chk({5'h0, accum_we, mem_we, done}, 8'h05);
    @(posedge mclk_i);
    #1;
    chk({5'h0, accum_we, mem_we, done}, 8'h00);
  endtask

  // Complement then adjust on consecutive edges, with no idle cycle.
  task run_back_to_back();
    @(posedge mclk_i);
    cpl <= 1'b1;
    mem <= 8'h3c;
    @(posedge mclk_i);
    cpl <= 1'b0;
    adj <= 1'b1;
    accum <= 8'h9a;
    hc <= 1'b0;
    cy <= 1'b0;
    #1;
    chk(accum_w, 8'hc3);
    chk({5'h0, accum_we, mem_we, done}, 8'h05);
    @(posedge mclk_i);
    adj <= 1'b0;
    #1;
    chk(mem_w, 8'h00);
    chk({6'h0, c_o, c_we}, 8'h03);
    chk(accum_w, 8'hc3);
    chk({5'h0, accum_we, mem_we, done}, 8'h03);
  endtask

  task end_sim();
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    #1;
    chk({5'h0, accum_we, mem_we, done}, 8'h00);
    run_complement(8'hff);
    run_complement(8'h00);
    run_complement(8'ha5);
    run_adjust(8'h2b, 1'b0, 1'b0, 8'h31, 1'b0);
    run_adjust(8'h23, 1'b1, 1'b0, 8'h29, 1'b0);
    run_adjust(8'hb3, 1'b0, 1'b0, 8'h13, 1'b1);
    run_adjust(8'h15, 1'b0, 1'b1, 8'h75, 1'b1);
    run_adjust(8'hcd, 1'b0, 1'b0, 8'h33, 1'b1);
    run_adjust(8'h45, 1'b0, 1'b0, 8'h45, 1'b0);
    run_adjust(8'h00, 1'b0, 1'b1, 8'h60, 1'b1);
    run_adjust(8'h9a, 1'b0, 1'b0, 8'h00, 1'b1);
    run_collision();
    run_back_to_back();
    end_sim();
  end
endmodule
